// [fpac_unit.sv]
`timescale 1ns/1ps
// ==========================================================
module fpac_unit
  import fpac_pkg::*;
#(
  parameter int NUM_REGS = 32
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic fpu_present,
  input wire logic fpu_enabled,
  input wire logic issue_valid,
  input wire fpac_issue_t issue,
  input wire logic [3:0] core_nzcv,
  input wire logic rf_we,
  input wire logic [FPAC_REG_AW-1:0] rf_waddr,
  input wire logic [FPAC_W-1:0] rf_wdata,
  input wire logic status_move,
  output fpac_wb_t wb,
  output fpac_cmp_t cmp,
  output logic [3:0] status_nzcv,
  output logic invalid_sticky,
  output logic undef_op,
  output logic [3:0] core_nzcv_out,
  output logic core_nzcv_load
);
  // refused while elaborating: register indices are only FPAC_REG_AW bits wide
  if (NUM_REGS < 2 || NUM_REGS > (1 << FPAC_REG_AW)) begin : g_num_regs_check
    $error("fpac_unit: NUM_REGS out of range");
  end

  // ==========================================================
  // register file
  logic [FPAC_W-1:0] regs_r [NUM_REGS];
  logic [FPAC_W-1:0] op_a, op_b, add_sum, abs_val;
  logic fire, cond_pass, avail;
  logic [FPAC_REG_AW-1:0] dest_sel;

  assign op_a = regs_r[issue.first];
  assign op_b = issue.cmp_zero ? FPAC_POS_ZERO : regs_r[issue.second];
  assign abs_val = {1'b0, regs_r[issue.second][FPAC_SIGN-1:0]};
  assign dest_sel = issue.dest_given ? issue.dest : issue.first;
  assign avail = fpu_present && fpu_enabled;

  // ==========================================================
  // condition evaluated on the core flags
  always_comb begin
    logic n, z, c, v;
    n = core_nzcv[3];
    z = core_nzcv[2];
    c = core_nzcv[1];
    v = core_nzcv[0];
    case (issue.cond)
      FPAC_COND_EQ: cond_pass = z;
      FPAC_COND_NE: cond_pass = !z;
      FPAC_COND_CS: cond_pass = c;
      FPAC_COND_CC: cond_pass = !c;
      FPAC_COND_MI: cond_pass = n;
      FPAC_COND_PL: cond_pass = !n;
      FPAC_COND_VS: cond_pass = v;
      FPAC_COND_VC: cond_pass = !v;
      FPAC_COND_HI: cond_pass = c && !z;
      FPAC_COND_LS: cond_pass = !c || z;
      FPAC_COND_GE: cond_pass = (n == v);
      FPAC_COND_LT: cond_pass = (n != v);
      FPAC_COND_GT: cond_pass = !z && (n == v);
      FPAC_COND_LE: cond_pass = z || (n != v);
      default: cond_pass = 1'b1;
    endcase
    if (!issue.cond_used) cond_pass = 1'b1;
  end

  assign fire = issue_valid && avail && cond_pass && (issue.op != FPAC_OP_NONE);

  fpac_adder u_add (
    .a(op_a),
    .b(regs_r[issue.second]),
    .sum(add_sum)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REGS; i++) regs_r[i] <= FPAC_POS_ZERO;
    end else if (clk_en) begin
      if (rf_we) regs_r[rf_waddr] <= rf_wdata;
      // execution wins over a same cycle load to the same register
      if (fire && issue.op == FPAC_OP_ABS) regs_r[issue.dest] <= abs_val;
      if (fire && issue.op == FPAC_OP_ADD) regs_r[dest_sel] <= add_sum;
    end
  end

  // ==========================================================
  // writeback report
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wb <= '0;
    end else if (clk_en) begin
      wb.valid <= fire && (issue.op == FPAC_OP_ABS || issue.op == FPAC_OP_ADD);
      wb.dest <= (issue.op == FPAC_OP_ABS) ? issue.dest : dest_sel;
      wb.data <= (issue.op == FPAC_OP_ABS) ? abs_val : add_sum;
    end
  end

  // ==========================================================
  // compare
  logic a_nan, b_nan, a_snan, b_snan, unord, eq, lt, is_cmp, inv;
  logic [3:0] nzcv_nxt;
  always_comb begin
    a_nan = (op_a[FPAC_EXP_HI:FPAC_EXP_LO] == FPAC_EXP_MAX) && (op_a[FPAC_MAN_W-1:0] != '0);
    b_nan = (op_b[FPAC_EXP_HI:FPAC_EXP_LO] == FPAC_EXP_MAX) && (op_b[FPAC_MAN_W-1:0] != '0);
    a_snan = a_nan && !op_a[FPAC_QUIET];
    b_snan = b_nan && !op_b[FPAC_QUIET];
    unord = a_nan || b_nan;
    // signed zeros are equal
    eq = (op_a == op_b) || ((op_a[FPAC_SIGN-1:0] == '0) && (op_b[FPAC_SIGN-1:0] == '0));
    if (op_a[FPAC_SIGN] != op_b[FPAC_SIGN])
      lt = op_a[FPAC_SIGN];
    else if (op_a[FPAC_SIGN])
      lt = op_a[FPAC_SIGN-1:0] > op_b[FPAC_SIGN-1:0];
    else
      lt = op_a[FPAC_SIGN-1:0] < op_b[FPAC_SIGN-1:0];
    if (unord) nzcv_nxt = FPAC_NZCV_UN;
    else if (eq) nzcv_nxt = FPAC_NZCV_EQ;
    else if (lt) nzcv_nxt = FPAC_NZCV_LT;
    else nzcv_nxt = FPAC_NZCV_GT;
    is_cmp = (issue.op == FPAC_OP_CMP) || (issue.op == FPAC_OP_CMPE);
    if (issue.op == FPAC_OP_CMPE) inv = unord;
    else inv = a_snan || b_snan;
  end

  // only compare sets status_nzcv, invalid_sticky and cmp.valid; cmp.nzcv follows every cycle, add included
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status_nzcv <= 4'h0;
      cmp <= '0;
      invalid_sticky <= 1'b0;
    end else if (clk_en) begin
      cmp.valid <= fire && is_cmp;
      cmp.nzcv <= nzcv_nxt;
      cmp.invalid_op <= fire && is_cmp && inv;
      if (fire && is_cmp) status_nzcv <= nzcv_nxt;
      if (fire && is_cmp && inv) invalid_sticky <= 1'b1;
    end
  end

  // ==========================================================
  // status to core move and unavailable reporting
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      core_nzcv_out <= 4'h0;
      core_nzcv_load <= 1'b0;
      undef_op <= 1'b0;
    end else if (clk_en) begin
      // a move in the same cycle as a compare sees the compare result
      core_nzcv_load <= status_move && avail;
      if (status_move && avail)
        core_nzcv_out <= (fire && is_cmp) ? nzcv_nxt : status_nzcv;
      undef_op <= issue_valid && !avail && (issue.op != FPAC_OP_NONE);
    end
  end

  // ==========================================================
  // checks
  property p_abs_sign;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && fire && issue.op == FPAC_OP_ABS) |=> (wb.valid && !wb.data[FPAC_SIGN]);
  endproperty
  a_abs_sign: assert property (p_abs_sign) else $error("abs kept sign");

  property p_abs_mag;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && fire && issue.op == FPAC_OP_ABS)
      |=> (wb.data[FPAC_SIGN-1:0] == $past(regs_r[issue.second][FPAC_SIGN-1:0]));
  endproperty
  a_abs_mag: assert property (p_abs_mag) else $error("abs magnitude wrong");

  property p_add_flags;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && !(fire && is_cmp)) |=> $stable(status_nzcv);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("flags moved");

  property p_gate;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && issue_valid && !avail) |=> (!wb.valid && !cmp.valid);
  endproperty
  a_gate: assert property (p_gate) else $error("ran while unavailable");

  property p_add_dest;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && fire && issue.op == FPAC_OP_ADD && !issue.dest_given)
      |=> (wb.dest == $past(issue.first));
  endproperty
  a_add_dest: assert property (p_add_dest) else $error("add dest wrong");

  property p_cmpe;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && fire && issue.op == FPAC_OP_CMPE && unord) |=> cmp.invalid_op;
  endproperty
  a_cmpe: assert property (p_cmpe) else $error("checked compare missed nan");

  property p_cmp_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && fire && issue.op == FPAC_OP_CMP && unord && !a_snan && !b_snan)
      |=> (!cmp.invalid_op && cmp.nzcv == FPAC_NZCV_UN);
  endproperty
  a_cmp_quiet: assert property (p_cmp_quiet) else $error("quiet nan raised");

  property p_eq;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && fire && is_cmp && op_a == op_b && !unord) |=> (status_nzcv == FPAC_NZCV_EQ);
  endproperty
  a_eq: assert property (p_eq) else $error("equal code wrong");

  property p_cond;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && issue_valid && issue.cond_used && !cond_pass) |=> (!wb.valid && !cmp.valid);
  endproperty
  a_cond: assert property (p_cond) else $error("failed condition executed");
endmodule

// [fpac_pkg.sv]
package fpac_pkg;

  // ==========================================================
  // operand layout
  localparam int FPAC_W = 32;
  localparam int FPAC_SIGN = 31;
  localparam int FPAC_EXP_HI = 30;
  localparam int FPAC_EXP_LO = 23;
  localparam int FPAC_QUIET = 22;
  localparam int FPAC_MAN_W = 23;
  localparam int FPAC_REG_AW = 5;
  localparam logic [7:0] FPAC_EXP_MAX = 8'h00ff;
  localparam logic [31:0] FPAC_POS_ZERO = 32'h0000_0000;

  // ==========================================================
  // compare outcomes as n,z,c,v
  localparam logic [3:0] FPAC_NZCV_EQ = 4'h6;
  localparam logic [3:0] FPAC_NZCV_LT = 4'h8;
  localparam logic [3:0] FPAC_NZCV_GT = 4'h2;
  localparam logic [3:0] FPAC_NZCV_UN = 4'h3;

  // ==========================================================
  // condition codes on the issue port
  localparam logic [3:0] FPAC_COND_EQ = 4'h0;
  localparam logic [3:0] FPAC_COND_NE = 4'h1;
  localparam logic [3:0] FPAC_COND_CS = 4'h2;
  localparam logic [3:0] FPAC_COND_CC = 4'h3;
  localparam logic [3:0] FPAC_COND_MI = 4'h4;
  localparam logic [3:0] FPAC_COND_PL = 4'h5;
  localparam logic [3:0] FPAC_COND_VS = 4'h6;
  localparam logic [3:0] FPAC_COND_VC = 4'h7;
  localparam logic [3:0] FPAC_COND_HI = 4'h8;
  localparam logic [3:0] FPAC_COND_LS = 4'h9;
  localparam logic [3:0] FPAC_COND_GE = 4'ha;
  localparam logic [3:0] FPAC_COND_LT = 4'hb;
  localparam logic [3:0] FPAC_COND_GT = 4'hc;
  localparam logic [3:0] FPAC_COND_LE = 4'hd;

  typedef enum logic [2:0] {
    FPAC_OP_NONE,
    FPAC_OP_ABS,
    FPAC_OP_ADD,
    FPAC_OP_CMP,
    FPAC_OP_CMPE
  } fpac_op_t;

  typedef struct packed {
    fpac_op_t op;
    logic [3:0] cond;
    logic cond_used;
    logic cmp_zero;
    logic dest_given;
    logic [FPAC_REG_AW-1:0] dest;
    logic [FPAC_REG_AW-1:0] first;
    logic [FPAC_REG_AW-1:0] second;
  } fpac_issue_t;

  typedef struct packed {
    logic valid;
    logic [FPAC_REG_AW-1:0] dest;
    logic [FPAC_W-1:0] data;
  } fpac_wb_t;

  typedef struct packed {
    logic valid;
    logic [3:0] nzcv;
    logic invalid_op;
  } fpac_cmp_t;

endpackage

// [fpac_adder.sv]
`timescale 1ns/1ps
// combinational single precision adder, round to nearest even,
// subnormals handled, nan inputs give the default quiet nan
module fpac_adder
  import fpac_pkg::*;
(
  input wire logic [FPAC_W-1:0] a,
  input wire logic [FPAC_W-1:0] b,
  output logic [FPAC_W-1:0] sum
);
  localparam logic [31:0] QNAN = 32'h7fc0_0000;
  localparam int XW = 27;

  logic [7:0] ea, eb, eg, es;
  logic [23:0] ma, mb;
  logic [XW-1:0] mg, ms, msh, mres;
  logic [XW:0] acc;
  logic sg, ss, sticky, sres, a_nan, b_nan, a_inf, b_inf, rnd;
  logic [8:0] ex;
  logic [24:0] mant;
  int sh, lz;

  always_comb begin
    // cleared on every pass so the carry branch does not hold a stale count
    lz = 0;
    ea = a[FPAC_EXP_HI:FPAC_EXP_LO];
    eb = b[FPAC_EXP_HI:FPAC_EXP_LO];
    a_nan = (ea == FPAC_EXP_MAX) && (a[FPAC_MAN_W-1:0] != '0);
    b_nan = (eb == FPAC_EXP_MAX) && (b[FPAC_MAN_W-1:0] != '0);
    a_inf = (ea == FPAC_EXP_MAX) && !a_nan;
    b_inf = (eb == FPAC_EXP_MAX) && !b_nan;
    ma = {(ea != 8'h00), a[FPAC_MAN_W-1:0]};
    mb = {(eb != 8'h00), b[FPAC_MAN_W-1:0]};
    if (ea == 8'h00) ea = 8'h01;
    if (eb == 8'h00) eb = 8'h01;
    if ({ea, ma} >= {eb, mb}) begin
      eg = ea; es = eb; sg = a[FPAC_SIGN]; ss = b[FPAC_SIGN];
      mg = {ma, 3'b000}; ms = {mb, 3'b000};
    end else begin
      eg = eb; es = ea; sg = b[FPAC_SIGN]; ss = a[FPAC_SIGN];
      mg = {mb, 3'b000}; ms = {ma, 3'b000};
    end
    sh = int'(eg - es);
    if (sh > XW) sh = XW;
    msh = ms >> sh;
    sticky = ((msh << sh) != ms);
    msh[0] = msh[0] | sticky;
    acc = (sg == ss) ? {1'b0, mg} + {1'b0, msh} : {1'b0, mg} - {1'b0, msh};
    sres = sg;
    ex = {1'b0, eg};
    if (acc[XW]) begin
      mres = acc[XW:1];
      mres[0] = mres[0] | acc[0];
      ex = ex + 9'd1;
    end else begin
      mres = acc[XW-1:0];
      lz = 0;
      for (int i = XW - 1; i >= 0; i--) begin
        if (mres[i]) break;
        lz++;
      end
      // keep exponent at least one so subnormals stay denormalised
      if (lz > int'(ex) - 1) lz = int'(ex) - 1;
      mres = mres << lz;
      ex = ex - 9'(lz);
      if (!mres[XW-1]) ex = 9'd0;
    end
    rnd = mres[2] && (mres[1] || mres[0] || mres[3]);
    mant = {1'b0, mres[XW-1:3]} + {24'd0, rnd};
    if (mant[24]) begin
      mant = mant >> 1;
      ex = ex + 9'd1;
    end else if (ex == 9'd0 && mant[23]) begin
      ex = 9'd1;
    end
    if (acc == '0) sres = a[FPAC_SIGN] & b[FPAC_SIGN];
    if (a_nan || b_nan || (a_inf && b_inf && a[FPAC_SIGN] != b[FPAC_SIGN]))
      sum = QNAN;
    else if (a_inf)
      sum = a;
    else if (b_inf)
      sum = b;
    else if (ex >= {1'b0, FPAC_EXP_MAX})
      sum = {sres, FPAC_EXP_MAX, 23'd0};
    else
      sum = {sres, ex[7:0], mant[22:0]};
  end
endmodule

// [fpac_core_model.sv]
`timescale 1ns/1ps
// ==========================================================
// core side: its flags change only through the status move
module fpac_core_model
  import fpac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] core_nzcv_out,
  input wire logic core_nzcv_load,
  output logic [3:0] core_nzcv
);
  logic [3:0] flags_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flags_r <= 4'h0;
    end else if (core_nzcv_load) begin
      flags_r <= core_nzcv_out;
    end
  end
  assign core_nzcv = flags_r;
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench
  import fpac_pkg::*;
();
  logic ref_clk = 0;
  logic rst_b = 0;
  logic clk_en = 1;
  logic fpu_present = 1;
  logic fpu_enabled = 1;
  logic issue_valid = 0;
  fpac_issue_t issue = '0;
  logic rf_we = 0;
  logic [4:0] rf_waddr = 5'h00;
  logic [31:0] rf_wdata = 32'h0000_0000;
  logic status_move = 0;
  logic [3:0] core_nzcv, status_nzcv, core_nzcv_out;
  logic invalid_sticky, undef_op, core_nzcv_load;
  fpac_wb_t wb;
  fpac_cmp_t cmp;
  int fail_count = 0;
  int n_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  fpac_unit #(.NUM_REGS(32)) i_fpac_unit (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .fpu_present(fpu_present), .fpu_enabled(fpu_enabled), .issue_valid(issue_valid),
    .issue(issue), .core_nzcv(core_nzcv), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .status_move(status_move), .wb(wb), .cmp(cmp),
    .status_nzcv(status_nzcv), .invalid_sticky(invalid_sticky), .undef_op(undef_op),
    .core_nzcv_out(core_nzcv_out), .core_nzcv_load(core_nzcv_load));
  fpac_core_model i_fpac_core_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .core_nzcv_out(core_nzcv_out), .core_nzcv_load(core_nzcv_load), .core_nzcv(core_nzcv));

  // ==========================================================
  // shared tasks; every task that waits on the clock starts and ends 1 ns after a rising edge
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // strobe dropped with a spare cycle so loads may follow each other
  task automatic load(input logic [4:0] a, input logic [31:0] d);
    rf_we = 1;
    rf_waddr = a;
    rf_wdata = d;
    tick();
    rf_we = 0;
    tick();
  endtask

  // leaves the request up so operations can run back to back
  task automatic op(input fpac_op_t o, input logic [4:0] d, f, s,
                    input logic dg, cz, cu, input logic [3:0] cd);
    issue_valid = 1;
    issue = '{o, cd, cu, cz, dg, d, f, s};
    tick();
  endtask

  task automatic idle();
    issue_valid = 0;
    tick();
  endtask

  task automatic move(input logic [3:0] exp);
    status_move = 1;
    tick();
    status_move = 0;
    chk("core load", 32'h0000_0001, 32'(core_nzcv_load));
    chk("core flags", 32'(exp), 32'(core_nzcv_out));
    tick();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_unavail();
    fpu_enabled = 0;
    op(FPAC_OP_ABS, 5'h03, 5'h00, 5'h01, 1'b1, 1'b0, 1'b0, 4'h0);
    chk("undef disabled", 32'h0000_0001, 32'(undef_op));
    chk("wb disabled", 32'h0000_0000, 32'(wb.valid));
    idle();
    fpu_enabled = 1;
    fpu_present = 0;
    op(FPAC_OP_CMP, 5'h00, 5'h01, 5'h02, 1'b0, 1'b0, 1'b0, 4'h0);
    chk("undef absent", 32'h0000_0001, 32'(undef_op));
    chk("cmp absent", 32'h0000_0000, 32'(cmp.valid));
    idle();
    fpu_present = 1;
    $display("test unavailable done");
  endtask

  task automatic t_abs();
    logic [31:0] vin [3] = '{32'hc0a0_0000, 32'h8000_0000, 32'hffc0_0000};
    for (int i = 0; i < 3; i++) begin
      load(5'h01, vin[i]);
      op(FPAC_OP_ABS, 5'h03, 5'h00, 5'h01, 1'b1, 1'b0, 1'b0, 4'h0);
      chk("abs valid", 32'h0000_0001, 32'(wb.valid));
      chk("abs dest", 32'h0000_0003, 32'(wb.dest));
      chk("abs data", {1'b0, vin[i][30:0]}, wb.data);
      idle();
    end
    $display("test absolute done");
  endtask

  // rows: less, greater, equal, quiet nan both kinds, signaling nan, two zero forms
  task automatic t_cmp();
    logic [31:0] a [8] = '{32'h3f80_0000, 32'h4000_0000, 32'h3f80_0000, 32'h7fc0_0000,
                           32'h7fc0_0000, 32'h3f80_0000, 32'h8000_0000, 32'hbf80_0000};
    logic [31:0] b [8] = '{32'h4000_0000, 32'h3f80_0000, 32'h3f80_0000, 32'h3f80_0000,
                           32'h3f80_0000, 32'h7f80_0001, 32'h7f80_0001, 32'h7f80_0001};
    logic [3:0] nz [8] = '{4'h8, 4'h2, 4'h6, 4'h3, 4'h3, 4'h3, 4'h6, 4'h8};
    logic [7:0] ce = 8'b1001_0100;
    logic [7:0] cz = 8'b1100_0000;
    logic [7:0] inv = 8'b0011_0000;
    logic sticky = 0;
    for (int i = 0; i < 8; i++) begin
      load(5'h01, a[i]);
      load(5'h02, b[i]);
      op(ce[i] ? FPAC_OP_CMPE : FPAC_OP_CMP, 5'h00, 5'h01, 5'h02, 1'b0, cz[i], 1'b0, 4'h0);
      sticky = sticky | inv[i];
      chk("cmp valid", 32'h0000_0001, 32'(cmp.valid));
      chk("cmp flags", 32'(nz[i]), 32'(cmp.nzcv));
      chk("cmp invalid", 32'(inv[i]), 32'(cmp.invalid_op));
      chk("status flags", 32'(nz[i]), 32'(status_nzcv));
      chk("no core load", 32'h0000_0000, 32'(core_nzcv_load));
      chk("sticky", 32'(sticky), 32'(invalid_sticky));
      idle();
      move(nz[i]);
    end
    $display("test compare done");
  endtask

  // core flags n=0 z=1 c=1 v=0: bit i of the mask says whether code i passes
  task automatic t_cond();
    logic [15:0] pass = 16'he6a5;
    load(5'h01, 32'h3f80_0000);
    load(5'h02, 32'h3f80_0000);
    op(FPAC_OP_CMP, 5'h00, 5'h01, 5'h02, 1'b0, 1'b0, 1'b0, 4'h0);
    idle();
    move(FPAC_NZCV_EQ);
    for (int i = 0; i < 16; i++) begin
      op(FPAC_OP_ADD, 5'h04, 5'h01, 5'h02, 1'b1, 1'b0, 1'b1, 4'(i));
      chk("cond exec", 32'(pass[i]), 32'(wb.valid));
    end
    op(FPAC_OP_ADD, 5'h04, 5'h01, 5'h02, 1'b1, 1'b0, 1'b0, FPAC_COND_NE);
    chk("cond unused", 32'h0000_0001, 32'(wb.valid));
    idle();
    $display("test condition done");
  endtask

  task automatic t_add();
    logic [31:0] sums [3] = '{32'h4040_0000, 32'h4040_0000, 32'h40a0_0000};
    load(5'h01, 32'h3f80_0000);
    load(5'h02, 32'h4000_0000);
    op(FPAC_OP_CMP, 5'h00, 5'h01, 5'h02, 1'b0, 1'b0, 1'b0, 4'h0);
    for (int i = 0; i < 3; i++) begin
      op(FPAC_OP_ADD, 5'h04, 5'h01, 5'h02, i == 0, 1'b0, 1'b0, 4'h0);
      chk("add sum", sums[i], wb.data);
      chk("add dest", i == 0 ? 32'h0000_0004 : 32'h0000_0001, 32'(wb.dest));
      chk("add status", 32'(FPAC_NZCV_LT), 32'(status_nzcv));
      chk("add cmp", 32'h0000_0000, 32'(cmp.valid));
      chk("add core", 32'h0000_0000, 32'(core_nzcv_load));
    end
    idle();
    $display("test add done");
  endtask

  // move issued with a compare sees that compare; a load to an add target loses
  task automatic t_fwd();
    load(5'h01, 32'h4000_0000);
    load(5'h02, 32'h3f80_0000);
    status_move = 1;
    op(FPAC_OP_CMP, 5'h00, 5'h01, 5'h02, 1'b0, 1'b0, 1'b0, 4'h0);
    status_move = 0;
    chk("fwd load", 32'h0000_0001, 32'(core_nzcv_load));
    chk("fwd flags", 32'(FPAC_NZCV_GT), 32'(core_nzcv_out));
    rf_we = 1;
    rf_waddr = 5'h04;
    rf_wdata = 32'h0000_0000;
    op(FPAC_OP_ADD, 5'h04, 5'h01, 5'h02, 1'b1, 1'b0, 1'b0, 4'h0);
    rf_we = 0;
    op(FPAC_OP_ABS, 5'h05, 5'h00, 5'h04, 1'b1, 1'b0, 1'b0, 4'h0);
    chk("add over load", 32'h4040_0000, wb.data);
    idle();
    $display("test forward done");
  endtask

  // ==========================================================
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_b = 1;
    t_unavail();
    t_abs();
    t_cmp();
    t_cond();
    t_add();
    t_fwd();
    end_sim();
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
endmodule
